/* logic/sdea_action_decode.v */
// decoder of the event action code into core requests
`timescale 1ns/1ps
`include "sdea_map.vh"
module sdea_action_decode #(
  parameter NUM_BKI = 4
) (
  input  wire [2:0] code,
  input  wire       brk_dis,
  output reg        halt,
  output reg        trap,
  output reg  [3:0] bki,
  output reg        pulse
);

  // ==========================================================
  // decode
  always @* begin
    halt  = 1'b0;
    trap  = 1'b0;
    bki   = 4'h0;
    pulse = 1'b0;
    case (code)
      `SDEA_ACT_NONE: begin
        pulse = 1'b0;
      end
      `SDEA_ACT_PULSE: begin
        pulse = 1'b1;
      end
      `SDEA_ACT_HALT: begin
        halt  = 1'b1;
        pulse = 1'b1;
      end
      `SDEA_ACT_TRAP: begin
        trap  = 1'b1;
        pulse = 1'b1;
      end
      default: begin
        if ({30'h00000000, code[1:0]} < NUM_BKI) begin
          bki[code[1:0]] = 1'b1;
        end
        pulse = 1'b1;
      end
    endcase
    if (brk_dis) begin
      pulse = 1'b0;
    end
  end

endmodule // sdea_action_decode

/* logic/sdea_counter_ctrl.v */
// run state of the task-mode performance counters
`timescale 1ns/1ps
`include "sdea_map.vh"
module sdea_counter_ctrl (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       fire,
  input  wire [1:0] action,
  output reg        run
);

  // ==========================================================
  // run state
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      run <= 1'b0;
    end else if (fire) begin
      case (action)
        `SDEA_CNT_KEEP: begin
          run <= run;
        end
        `SDEA_CNT_START: begin
          run <= 1'b1;
        end
        `SDEA_CNT_STOP: begin
          run <= 1'b0;
        end
        default: begin
          run <= ~run;
        end
      endcase
    end
  end

endmodule // sdea_counter_ctrl

/* logic/sdea_map.vh */
// register map and constants for the software debug event action block
//
// Contract
// - on a software event the counter-action field 00 leaves the task-mode counters alone, 01 starts them, 10 stops them.
// - counter-action field 11 toggles the counter run state on each event.
// - on a software event the suspend-out level takes the value of the suspend-level bit.
// - with break-out disabled no event ever pulses the break-out line, while other effects remain.
// - with break-out enabled the break-out line pulses as the action code asks; 000 does nothing, 001 pulses only.
// - a readable and writable break sequencing select bit picks break-after-make (0) or break-before-make (1).
// - the three-bit action code is decoded as the event's debug action, with 000 doing nothing at all.
// - action code 010 halts the core and pulses break-out unless disabled.
// - action code 011 raises a breakpoint trap and pulses break-out unless disabled.
// - action code 100 raises breakpoint interrupt 0 and pulses break-out unless disabled.
// - action codes 101, 110, 111 raise breakpoint interrupts 1, 2, 3 where present, with the break-out pulse unless disabled.
// - a code naming an absent breakpoint interrupt performs no core action.
// - the configuration register resets to zero so nothing happens after reset.
`ifndef SDEA_MAP_VH
`define SDEA_MAP_VH

// ==========================================================
// register offsets
`define SDEA_OFS_CFG        16'hFD10
`define SDEA_OFS_STATUS     16'hFD14
`define SDEA_OFS_IRQ_STAT   16'hFD18
`define SDEA_OFS_IRQ_MASK   16'hFD1C

// ==========================================================
// configuration fields
`define SDEA_CNT_HI         7
`define SDEA_CNT_LO         6
`define SDEA_SUSPEND_LEVEL_BIT_BIT       5
`define SDEA_BOD_BIT        4
`define SDEA_BBM_BIT        3
`define SDEA_EVENT_ACTION_CODE_HI        2
`define SDEA_EVENT_ACTION_CODE_LO        0
`define SDEA_CFG_WMASK      32'h000000FF
`define SDEA_CFG_RESET      8'h00

// ==========================================================
// counter actions
`define SDEA_CNT_KEEP       2'h0
`define SDEA_CNT_START      2'h1
`define SDEA_CNT_STOP       2'h2
`define SDEA_CNT_TOGGLE     2'h3

// ==========================================================
// action codes
`define SDEA_ACT_NONE       3'h0
`define SDEA_ACT_PULSE      3'h1
`define SDEA_ACT_HALT       3'h2
`define SDEA_ACT_TRAP       3'h3
`define SDEA_ACT_BKI0       3'h4

// ==========================================================
// interrupt status bits
`define SDEA_IRQ_EVENT      0
`define SDEA_IRQ_BREAKOUT   1
`define SDEA_IRQ_CORE       2
`define SDEA_IRQ_WIDTH      3

`endif

/* logic/sdea_top.v */
// software debug event action dispatcher with register port
`timescale 1ns/1ps
`include "sdea_map.vh"
module sdea_top #(
  parameter NUM_BKI = 4
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        sw_event,
  output reg         perf_run,
  output reg         suspend_out,
  output reg         break_out_line,
  output reg         break_sequencing_select,
  output reg         halt_req,
  output reg         trap_req,
  output reg  [3:0]  bki_req,
  output reg         irq
);

  // ==========================================================
  // configuration register
  reg  [7:0]                 cfg;
  reg  [`SDEA_IRQ_WIDTH-1:0] irq_stat;
  reg  [`SDEA_IRQ_WIDTH-1:0] irq_mask;
  wire                       dec_halt;
  wire                       dec_trap;
  wire [3:0]                 dec_bki;
  wire                       dec_pulse;
  wire                       run_state;
  wire [`SDEA_IRQ_WIDTH-1:0] ev_set;
  wire [`SDEA_IRQ_WIDTH-1:0] next_irq_stat;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg <= `SDEA_CFG_RESET;
    end else if (reg_wr && reg_addr == `SDEA_OFS_CFG) begin
      cfg <= reg_wdata[7:0];
    end
  end

  // ==========================================================
  // decode and counter control
  sdea_action_decode #(
    .NUM_BKI (NUM_BKI)
  ) u_decode (
    .code    (cfg[`SDEA_EVENT_ACTION_CODE_HI:`SDEA_EVENT_ACTION_CODE_LO]),
    .brk_dis (cfg[`SDEA_BOD_BIT]),
    .halt    (dec_halt),
    .trap    (dec_trap),
    .bki     (dec_bki),
    .pulse   (dec_pulse)
  );

  sdea_counter_ctrl u_counter (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .fire    (sw_event),
    .action  (cfg[`SDEA_CNT_HI:`SDEA_CNT_LO]),
    .run     (run_state)
  );

  // ==========================================================
  // event outputs
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      perf_run                <= 1'b0;
      suspend_out             <= 1'b0;
      break_out_line          <= 1'b0;
      break_sequencing_select <= 1'b0;
      halt_req                <= 1'b0;
      trap_req                <= 1'b0;
      bki_req                 <= 4'h0;
    end else begin
      perf_run                <= run_state;
      break_sequencing_select <= cfg[`SDEA_BBM_BIT];
      if (sw_event) begin
        suspend_out <= cfg[`SDEA_SUSPEND_LEVEL_BIT_BIT];
      end
      break_out_line <= sw_event & dec_pulse;
      halt_req       <= sw_event & dec_halt;
      trap_req       <= sw_event & dec_trap;
      bki_req        <= {4{sw_event}} & dec_bki;
    end
  end

  // ==========================================================
  // interrupt status, set wins over clear
  assign ev_set        = {sw_event & (dec_halt | dec_trap | (|dec_bki)), sw_event & dec_pulse, sw_event};
  assign next_irq_stat = (reg_wr && reg_addr == `SDEA_OFS_IRQ_STAT) ?
                         ((irq_stat & ~reg_wdata[`SDEA_IRQ_WIDTH-1:0]) | ev_set) : (irq_stat | ev_set);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_stat <= {`SDEA_IRQ_WIDTH{1'b0}};
      irq_mask <= {`SDEA_IRQ_WIDTH{1'b0}};
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (reg_wr && reg_addr == `SDEA_OFS_IRQ_MASK) begin
        irq_mask <= reg_wdata[`SDEA_IRQ_WIDTH-1:0];
      end
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // read port
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SDEA_OFS_CFG: begin
          reg_rdata <= {24'h000000, cfg};
        end
        `SDEA_OFS_STATUS: begin
          reg_rdata <= {29'h00000000, break_sequencing_select, suspend_out, run_state};
        end
        `SDEA_OFS_IRQ_STAT: begin
          reg_rdata <= {29'h00000000, irq_stat};
        end
        `SDEA_OFS_IRQ_MASK: begin
          reg_rdata <= {29'h00000000, irq_mask};
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // sdea_top

/* testbench/sdea_assertions.sv */
// port checks for the software debug event action block
`timescale 1ns/1ps
module sdea_assertions #(
  parameter NUM_BKI = 4
) (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        sw_event,
  input wire        perf_run,
  input wire        suspend_out,
  input wire        break_out_line,
  input wire        halt_req,
  input wire        trap_req,
  input wire [3:0]  bki_req
);
  // ==========================================================
  // shadow of the configuration register
  reg [7:0] c;
  always @(posedge sys_clk)
    if (sys_rst) c <= 8'h00;
    else if (reg_wr && reg_addr == 16'hFD10) c <= reg_wdata[7:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // checks
  a_halt_code: assert property (sw_event && c[2:0] == 3'h2 |=> halt_req)
    else $error("halt request missing");
  a_trap_code: assert property (sw_event && c[2:0] == 3'h3 |=> trap_req)
    else $error("trap request missing");
  a_bki_sel: assert property (sw_event |=> bki_req == (($past(c[2])
    && $past(c[1:0]) < NUM_BKI) ? 4'h1 << $past(c[1:0]) : 4'h0)) else $error("wrong interrupt request");
  a_brk_gate: assert property (sw_event |=> break_out_line ==
    (!$past(c[4]) && $past(c[2:0]) != 3'h0)) else $error("wrong break-out pulse");
  a_none_quiet: assert property (sw_event && c[2:0] == 3'h0 |=>
    !break_out_line && !halt_req && !trap_req && bki_req == 4'h0) else $error("action on code zero");
  a_suspend_level_bit_lvl: assert property (sw_event |=> suspend_out == $past(c[5]))
    else $error("wrong suspend level");
  a_cnt_set: assert property (sw_event && c[7] != c[6] |=> ##1 perf_run == $past(c[6], 2))
    else $error("wrong counter run state");
  a_cnt_toggle: assert property (sw_event && c[7:6] == 2'h3 |=> ##1 perf_run != $past(perf_run))
    else $error("counter state not toggled");
  a_rsv_zero: assert property (reg_rd && reg_addr == 16'hFD10 |=> reg_rdata[31:8] == 24'h0)
    else $error("reserved bits not zero");
  cover property (sw_event && c[2:0] == 3'h7);
  cover property (sw_event && c[4]);
  cover property (sw_event && c[7:6] == 2'h3);
endmodule // sdea_assertions

/* testbench/sdea_core_model.sv */
// core side model that raises software debug events
`timescale 1ns/1ps
module sdea_core_model (
  input  wire sys_clk,
  output reg  sw_event
);
  initial sw_event = 1'b0;
  // ==========================================================
  // one-cycle event pulse
  task fire;
    begin
      @(posedge sys_clk);
      sw_event <= 1'b1;
      @(posedge sys_clk);
      sw_event <= 1'b0;
    end
  endtask
endmodule // sdea_core_model

/* testbench/sdea_top_test.sv */
// testbench for the software debug event action block
`timescale 1ns/1ps
`include "sdea_map.vh"
module sdea_top_test;
  reg         sys_clk = 0;
  reg         sys_rst = 1;
  reg  [15:0] reg_addr = 0;
  reg  [31:0] reg_wdata = 0;
  reg         reg_wr = 0;
  reg         reg_rd = 0;
  wire [31:0] reg_rdata;
  wire        sw_event, perf_run, suspend_out, break_out_line, bsel, halt_req, trap_req, irq;
  wire [3:0]  bki_req;
  int         mismatches = 0;
  int         samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  sdea_top #(.NUM_BKI(3)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sw_event(sw_event), .perf_run(perf_run), .suspend_out(suspend_out),
    .break_out_line(break_out_line), .break_sequencing_select(bsel), .halt_req(halt_req),
    .trap_req(trap_req), .bki_req(bki_req), .irq(irq));
  sdea_core_model core (.sys_clk(sys_clk), .sw_event(sw_event));
  // ==========================================================
  // shared tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        mismatches++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 0;
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
    end
  endtask
  task ev(input [6:0] e);
    begin
      core.fire;
      #1 chk({break_out_line, halt_req, trap_req, bki_req}, e);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    begin
      rd(`SDEA_OFS_CFG, 32'h0);
      rd(16'hFD40, 32'h0);
      wr(`SDEA_OFS_CFG, 32'hFFFFFFFF);
      rd(`SDEA_OFS_CFG, 32'h000000FF);
      chk(bsel, 1);
      rd(`SDEA_OFS_STATUS, 32'h4);
      wr(`SDEA_OFS_CFG, 32'h0);
      rd(`SDEA_OFS_CFG, 32'h0);
      chk(bsel, 0);
    end
  endtask
  task t_codes;
    reg [3:0] b;
    begin
      for (int i = 0; i < 16; i++) begin
        b = (i[2] && i[1:0] < 3) ? 4'h1 << i[1:0] : 4'h0;
        wr(`SDEA_OFS_CFG, {27'h0, i[3], 1'b0, i[2:0]});
        ev({!i[3] && i[2:0] != 0, i[2:0] == 2, i[2:0] == 3, b});
      end
    end
  endtask
  task t_count(input [7:0] c, input r, input s);
    begin
      wr(`SDEA_OFS_CFG, {24'h0, c});
      core.fire;
      @(posedge sys_clk);
      #1 chk({perf_run, suspend_out}, {r, s});
      rd(`SDEA_OFS_STATUS, {29'h0, c[3], s, r});
    end
  endtask
  task t_irq;
    begin
      wr(`SDEA_OFS_IRQ_STAT, 32'h7);
      wr(`SDEA_OFS_CFG, 32'h2);
      ev(7'h60);
      rd(`SDEA_OFS_IRQ_STAT, 32'h7);
      chk(irq, 0);
      wr(`SDEA_OFS_IRQ_MASK, 32'h4);
      rd(`SDEA_OFS_IRQ_MASK, 32'h4);
      chk(irq, 1);
      wr(`SDEA_OFS_IRQ_STAT, 32'h4);
      rd(`SDEA_OFS_IRQ_STAT, 32'h3);
      chk(irq, 0);
    end
  endtask
  task results;
    begin
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    #1 chk({perf_run, suspend_out, break_out_line, halt_req, trap_req, bki_req, irq}, 0);
    t_regs;
    t_codes;
    t_count(8'h60, 1, 1);
    t_count(8'hC0, 0, 0);
    t_count(8'hC0, 1, 0);
    t_count(8'h20, 1, 1);
    t_count(8'h80, 0, 0);
    t_irq;
    results;
  end
  initial begin
    #200000;
    mismatches++;
    results;
  end
endmodule // sdea_top_test
bind sdea_top sdea_assertions #(.NUM_BKI(NUM_BKI)) chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sw_event(sw_event), .perf_run(perf_run), .suspend_out(suspend_out), .break_out_line(break_out_line),
  .halt_req(halt_req), .trap_req(trap_req), .bki_req(bki_req));
